// ===== pkg/palette_dac_pkg.sv
// Types shared by the palette host port and its palette store.
// Assumes nothing beyond a SystemVerilog compiler.
package palette_dac_pkg;
   typedef enum logic [1:0] {phase_red, phase_green, phase_blue} color_phase_type;
   typedef enum logic {mode_write, mode_read} access_mode_type;
   typedef logic [7:0] byte_type;
   typedef logic [23:0] color_type;
endpackage

// ===== pkg/palette_dac_regs.svh
// Register-select codes, field positions and reset values of the palette host port.
// Assumes inclusion after palette_dac_pkg has been compiled.
// Behaviour
// - Reset selects six-bit palette access; a control bit selects six or eight bits.
// - Six-bit write: drop host 7:6, host 5:0 to internal 7:2, 1:0 zero.
// - Six-bit read: internal 7:2 to host 5:0, host 7:6 read zero.
// - Eight-bit mode passes all host data bits unchanged both ways.
// - Translation only at host port; color registers always move eight-bit values.
// - Palette accesses follow pixel clock; hold previous pixel during internal write.
// - Read-mode address read returns address, or last access status if format bit set.
// - Status reads 0x00 after write-mode address load, 0x03 after read-mode.
// - Pixel mask at select 010, never disturbs a palette sequence.
// - Pixel mask applies directly to pixels, not synchronised to palette accesses.
// - Eleven-bit index: high part at select 101, low part at select 100.
// - Select 110 writes or reads the location addressed by the index.
// - Index increments after indexed data access only when auto-increment bit set.
// - Index and indexed accesses leave palette sequences undisturbed.
// - Select 000 starts write sequence, 011 read sequence, 001 carries data.
// - Palette address steps every third data access, wrapping 0xff to 0x00.
// - Data writes fill red, green, blue; third write stores 24 bits.
`ifndef PALETTE_DAC_REGS_SVH
`define PALETTE_DAC_REGS_SVH

`define RS_PAL_WADDR 3'h0
`define RS_PAL_DATA 3'h1
`define RS_PIXEL_MASK 3'h2
`define RS_PAL_RADDR 3'h3
`define RS_INDEX_LOW 3'h4
`define RS_INDEX_HIGH 3'h5
`define RS_INDEXED_DATA 3'h6
`define RS_INDEX_CTRL 3'h7

`define PAL_STATUS_WRITE 8'h00
`define PAL_STATUS_READ 8'h03

`define IDX_MISC1 11'h070
`define IDX_MISC2 11'h071
`define MISC1_RFMT_BIT 0
`define MISC2_COLRES_BIT 2
`define CTRL_AUTOINC_BIT 0
`define CURSOR_BASE 11'h100
`define CURSOR_LAST 11'h4ff

`define PIXEL_MASK_RESET 8'hff
`define INDEX_CTRL_RESET 8'h00
`define MISC_RESET 8'h00

`endif

// ===== pkg/palette_port_if.sv
// Internal port between the host access logic and the palette store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface palette_port_if;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [23:0] wdata;
   logic [23:0] rdata;
   logic [7:0] pixel_mask;
   modport access_side (output wr_en, output rd_en, output addr, output wdata,
      output pixel_mask, input rdata);
   modport store_side (input wr_en, input rd_en, input addr, input wdata,
      input pixel_mask, output rdata);
endinterface

// ===== rtl/palette_dac_host_access.sv
// Host port of the palette DAC: palette sequencing, pixel mask and indexed space.
// Assumes host strobes are one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`include "palette_dac_regs.svh"
module palette_dac_host_access (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] register_select,
   input wire logic [7:0] host_data_in,
   input wire logic host_wr,
   input wire logic host_rd,
   output palette_dac_pkg::byte_type host_data_out,
   output logic host_data_oe_n,
   input wire logic [7:0] pixel_index,
   output palette_dac_pkg::color_type pixel_color
);
   import palette_dac_pkg::*;

   logic rst_sync1_reg;
   logic rst_n;
   palette_port_if pal_port ();

   byte_type color_reg [0:2];
   byte_type pal_addr_reg;
   byte_type pal_status_reg;
   byte_type pixel_mask_reg;
   byte_type index_ctrl_reg;
   byte_type misc1_reg;
   byte_type misc2_reg;
   byte_type ctrl_mem [0:255];
   byte_type cursor_mem [0:1023];
   color_phase_type phase_reg;
   access_mode_type mode_reg;
   logic [10:0] index_reg;
   logic store_req_reg;
   logic fetch_req_reg;
   logic fetch_load_reg;
   logic read_active_reg;

   logic wide_access;
   logic status_format;
   logic auto_inc;
   logic data_wr;
   logic data_rd;
   logic idx_access;
   logic in_cursor;
   logic [9:0] cursor_addr;
   byte_type host_to_color;
   byte_type color_to_host;
   byte_type indexed_rdata;
   byte_type read_mux;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync1_reg <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_sync1_reg <= 1'b1;
         rst_n <= rst_sync1_reg;
      end
   end

   // Decoded controls
   assign wide_access = misc2_reg[`MISC2_COLRES_BIT];
   assign status_format = misc1_reg[`MISC1_RFMT_BIT];
   assign auto_inc = index_ctrl_reg[`CTRL_AUTOINC_BIT];
   assign data_wr = host_wr && (register_select == `RS_PAL_DATA);
   assign data_rd = host_rd && (register_select == `RS_PAL_DATA);
   assign idx_access = (host_wr || host_rd) && (register_select == `RS_INDEXED_DATA);
   assign in_cursor = (index_reg >= `CURSOR_BASE) && (index_reg <= `CURSOR_LAST);
   assign cursor_addr = 10'(index_reg - `CURSOR_BASE);

   // Width translation sits only between host bus and color registers
   always_comb begin
      if (wide_access) begin
         host_to_color = host_data_in;
         color_to_host = color_reg[phase_reg];
      end else begin
         host_to_color = {host_data_in[5:0], 2'b00};
         color_to_host = {2'b00, color_reg[phase_reg][7:2]};
      end
   end

   // Palette port drive; the full 24 bits always go through untouched
   assign pal_port.wr_en = store_req_reg;
   assign pal_port.rd_en = fetch_req_reg;
   assign pal_port.addr = pal_addr_reg;
   assign pal_port.wdata = {color_reg[0], color_reg[1], color_reg[2]};
   assign pal_port.pixel_mask = pixel_mask_reg;

   // Address loads start a sequence; data accesses step it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pal_addr_reg <= 8'h00;
         phase_reg <= phase_red;
         mode_reg <= mode_write;
         pal_status_reg <= `PAL_STATUS_WRITE;
      end else if (host_wr && register_select == `RS_PAL_WADDR) begin
         pal_addr_reg <= host_data_in;
         phase_reg <= phase_red;
         mode_reg <= mode_write;
         pal_status_reg <= `PAL_STATUS_WRITE;
      end else if (host_wr && register_select == `RS_PAL_RADDR) begin
         pal_addr_reg <= host_data_in;
         phase_reg <= phase_red;
         mode_reg <= mode_read;
         pal_status_reg <= `PAL_STATUS_READ;
      end else begin
         if (store_req_reg || fetch_load_reg) begin
            pal_addr_reg <= 8'(pal_addr_reg + 8'h01);
         end
         if (data_wr || data_rd) begin
            case (phase_reg)
               phase_red: phase_reg <= phase_green;
               phase_green: phase_reg <= phase_blue;
               phase_blue: phase_reg <= phase_red;
               default: phase_reg <= phase_red;
            endcase
         end
      end
   end

   // Internal palette write follows the third data write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         store_req_reg <= 1'b0;
      end else begin
         store_req_reg <= data_wr && (phase_reg == phase_blue);
      end
   end

   // Internal palette read after a read-mode load or a third data read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_req_reg <= 1'b0;
         fetch_load_reg <= 1'b0;
      end else begin
         fetch_req_reg <= (host_wr && register_select == `RS_PAL_RADDR)
            || (data_rd && phase_reg == phase_blue);
         fetch_load_reg <= fetch_req_reg;
      end
   end

   // Color holding registers always keep eight-bit values
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         color_reg[0] <= 8'h00;
         color_reg[1] <= 8'h00;
         color_reg[2] <= 8'h00;
      end else if (fetch_load_reg) begin
         color_reg[0] <= pal_port.rdata[23:16];
         color_reg[1] <= pal_port.rdata[15:8];
         color_reg[2] <= pal_port.rdata[7:0];
      end else if (data_wr) begin
         color_reg[phase_reg] <= host_to_color;
      end
   end

   // Pixel mask, touching nothing of the palette sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pixel_mask_reg <= `PIXEL_MASK_RESET;
      end else if (host_wr && register_select == `RS_PIXEL_MASK) begin
         pixel_mask_reg <= host_data_in;
      end
   end

   // Index register: byte loads and optional step after indexed access
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index_reg <= 11'h000;
      end else if (host_wr && register_select == `RS_INDEX_LOW) begin
         index_reg[7:0] <= host_data_in;
      end else if (host_wr && register_select == `RS_INDEX_HIGH) begin
         index_reg[10:8] <= host_data_in[2:0];
      end else if (idx_access && auto_inc) begin
         index_reg <= 11'(index_reg + 11'h001);
      end
   end

   // Index control byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index_ctrl_reg <= `INDEX_CTRL_RESET;
      end else if (host_wr && register_select == `RS_INDEX_CTRL) begin
         index_ctrl_reg <= host_data_in;
      end
   end

   // Control bytes with reset values that steer the palette path
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         misc1_reg <= `MISC_RESET;
         misc2_reg <= `MISC_RESET;
      end else if (host_wr && register_select == `RS_INDEXED_DATA) begin
         if (index_reg == `IDX_MISC1) begin
            misc1_reg <= host_data_in;
         end
         if (index_reg == `IDX_MISC2) begin
            misc2_reg <= host_data_in;
         end
      end
   end

   // Plain indexed storage; no reset, software loads it
   always_ff @(posedge clk) begin
      if (host_wr && register_select == `RS_INDEXED_DATA) begin
         if (in_cursor) begin
            cursor_mem[cursor_addr] <= host_data_in;
         end else if (index_reg[10:8] == 3'h0) begin
            ctrl_mem[index_reg[7:0]] <= host_data_in;
         end
      end
   end

   // Indexed read data; unmapped locations read zero
   always_comb begin
      if (index_reg == `IDX_MISC1) begin
         indexed_rdata = misc1_reg;
      end else if (index_reg == `IDX_MISC2) begin
         indexed_rdata = misc2_reg;
      end else if (in_cursor) begin
         indexed_rdata = cursor_mem[cursor_addr];
      end else if (index_reg[10:8] == 3'h0) begin
         indexed_rdata = ctrl_mem[index_reg[7:0]];
      end else begin
         indexed_rdata = 8'h00;
      end
   end

   // Host read selection
   always_comb begin
      case (register_select)
         `RS_PAL_WADDR: read_mux = pal_addr_reg;
         `RS_PAL_DATA: read_mux = color_to_host;
         `RS_PIXEL_MASK: read_mux = pixel_mask_reg;
         `RS_PAL_RADDR: read_mux = status_format ? pal_status_reg : pal_addr_reg;
         `RS_INDEX_LOW: read_mux = index_reg[7:0];
         `RS_INDEX_HIGH: read_mux = {5'h00, index_reg[10:8]};
         `RS_INDEXED_DATA: read_mux = indexed_rdata;
         `RS_INDEX_CTRL: read_mux = index_ctrl_reg;
         default: read_mux = 8'h00;
      endcase
   end

   // Read data is registered and driven for one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         host_data_out <= 8'h00;
         read_active_reg <= 1'b0;
      end else begin
         read_active_reg <= host_rd;
         if (host_rd) begin
            host_data_out <= read_mux;
         end
      end
   end

   assign host_data_oe_n = ~read_active_reg;

   // Palette storage and pixel lookup
   palette_store store (
      .clk(clk),
      .rst_n(rst_n),
      .port(pal_port),
      .pixel_index(pixel_index),
      .pixel_color(pixel_color)
   );
endmodule

// ===== rtl/palette_store.sv
// 256 x 24 color palette with the pixel lookup path.
// Assumes the pixel index arrives on the same clock as host accesses.
`timescale 1ns/1ps
module palette_store (
   input wire logic clk,
   input wire logic rst_n,
   palette_port_if.store_side port,
   input wire logic [7:0] pixel_index,
   output logic [23:0] pixel_color
);
   import palette_dac_pkg::*;

   color_type palette_mem [0:255];
   color_type rdata_reg;

   assign port.rdata = rdata_reg;

   // Host side storage; the lookup below shares the array
   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         palette_mem[port.addr] <= port.wdata;
      end
   end

   // Internal palette read, answered one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 24'h000000;
      end else if (port.rd_en) begin
         rdata_reg <= palette_mem[port.addr];
      end
   end

   // Mask is applied straight on the pixel path, so a change shows at the next clock edge unless a palette write holds the pixel
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pixel_color <= 24'h000000;
      end else if (port.wr_en) begin
         pixel_color <= pixel_color;
      end else begin
         pixel_color <= palette_mem[pixel_index & port.pixel_mask];
      end
   end
endmodule

// ===== tb/host_cpu_model.sv
// Host processor model on the eight-address register port.
// Assumes clk doubles as the always-running pixel clock.
`timescale 1ns/1ps
module host_cpu_model (
   input wire logic clk,
   input wire palette_dac_pkg::byte_type host_data_out,
   output logic [2:0] register_select,
   output logic [7:0] host_data_in,
   output logic host_wr,
   output logic host_rd
);
   import palette_dac_pkg::*;
   // Idle bus from time zero
   initial begin
      register_select = 3'h0;
      host_data_in = 8'h00;
      host_wr = 1'b0;
      host_rd = 1'b0;
   end
   // One cycle: strobe and qualifiers all change together after an edge
   task automatic put(input logic w, input logic r, input logic [2:0] rs, input logic [7:0] d);
      @(posedge clk);
      host_wr <= w;
      host_rd <= r;
      register_select <= rs;
      host_data_in <= d;
   endtask
   // Released data shows the inverse so a stale byte never looks valid
   task automatic bus_wr(input logic [2:0] rs, input logic [7:0] d);
      put(1'b1, 1'b0, rs, d);
      put(1'b0, 1'b0, rs, ~d);
   endtask
   // Clock never stops, so palette and cursor reads stay valid
   task automatic bus_rd(input logic [2:0] rs, output logic [7:0] q);
      put(1'b0, 1'b1, rs, ~host_data_in);
      put(1'b0, 1'b0, rs, host_data_in);
      #1 q = host_data_out;
   endtask
   // Back-to-back write then read of one select
   task automatic bus_wr_rd(input logic [2:0] rs, input logic [7:0] d, output logic [7:0] q);
      put(1'b1, 1'b0, rs, d);
      bus_rd(rs, q);
   endtask
endmodule

// ===== tb/palette_dac_host_access_monitor.sv
// Port checker for the palette host access block.
// Assumes one clock domain and one-cycle host strobes.
`timescale 1ns/1ps
module palette_dac_host_access_monitor (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [2:0] register_select,
   input wire logic [7:0] host_data_in,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire palette_dac_pkg::byte_type host_data_out,
   input wire logic host_data_oe_n
);
   import palette_dac_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Write a select, then read it back on the next cycle
   sequence s_wr_rd(logic [2:0] rs);
      host_wr && register_select == rs ##1 host_rd && register_select == rs;
   endsequence
   property p_read_answer;
      host_rd |=> !host_data_oe_n;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not driven");
   property p_idle_release;
      !host_rd |=> host_data_oe_n;
   endproperty
   a_idle_release: assert property (p_idle_release) else $error("bus driven idle");
   property p_data_hold;
      !host_rd |=> $stable(host_data_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("read data moved");
   property p_mask;
      s_wr_rd(3'h2) |=> host_data_out == $past(host_data_in, 2);
   endproperty
   a_mask: assert property (p_mask) else $error("mask readback wrong");
   property p_addr;
      s_wr_rd(3'h0) |=> host_data_out == $past(host_data_in, 2);
   endproperty
   a_addr: assert property (p_addr) else $error("address readback wrong");
   property p_low;
      s_wr_rd(3'h4) |=> host_data_out == $past(host_data_in, 2);
   endproperty
   a_low: assert property (p_low) else $error("index low readback wrong");
   property p_high;
      s_wr_rd(3'h5) |=> host_data_out == ($past(host_data_in, 2) & 8'h07);
   endproperty
   a_high: assert property (p_high) else $error("index high readback wrong");
   property p_ctrl;
      s_wr_rd(3'h7) |=> ((host_data_out ^ $past(host_data_in, 2)) & 8'h01) == 8'h00;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("step bit readback wrong");
   property p_high_zero;
      host_rd && register_select == 3'h5 |=> host_data_out[7:3] == 5'h00;
   endproperty
   a_high_zero: assert property (p_high_zero) else $error("index high too wide");
   c_pal_write: cover property (host_wr && register_select == 3'h1);
   c_pal_read: cover property (host_rd && register_select == 3'h1);
   c_indexed: cover property (host_rd && register_select == 3'h6);
endmodule

bind palette_dac_host_access palette_dac_host_access_monitor palette_dac_host_access_monitor_inst (
   .clk, .arst_n, .register_select, .host_data_in, .host_wr, .host_rd, .host_data_out,
   .host_data_oe_n);

// ===== tb/palette_dac_host_access_tb_top.sv
// Self-checking bench for the palette host access block.
// Assumes the host model and the port checker compiled beside it.
`timescale 1ns/1ps
module palette_dac_host_access_tb_top;
   import palette_dac_pkg::*;
   typedef struct {logic [2:0] rs; logic [7:0] d; logic [7:0] exp;} row_type;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [2:0] register_select;
   logic [7:0] host_data_in;
   logic host_wr;
   logic host_rd;
   byte_type host_data_out;
   logic host_data_oe_n;
   logic [7:0] pixel_index = 8'hff;
   color_type pixel_color;
   logic [7:0] q;
   int err_total = 0;
   int checks_done = 0;
   row_type rows [5] = '{'{3'h2, 8'ha5, 8'ha5}, '{3'h4, 8'h3c, 8'h3c},
      '{3'h5, 8'hff, 8'h07}, '{3'h7, 8'h00, 8'h00}, '{3'h0, 8'h7e, 8'h7e}};
   palette_dac_host_access palette_dac_host_access_inst (.clk, .arst_n, .register_select,
      .host_data_in, .host_wr, .host_rd, .host_data_out, .host_data_oe_n, .pixel_index,
      .pixel_color);
   host_cpu_model host_cpu_model_inst (.clk, .host_data_out, .register_select,
      .host_data_in, .host_wr, .host_rd);
   // 100 ns period
   always #50 clk = ~clk;
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk24(input string what, input color_type exp, input color_type got);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("mismatches %0d of %0d checks", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [2:0] rs, input logic [7:0] d);
      host_cpu_model_inst.bus_wr(rs, d);
   endtask
   task automatic rd(input logic [2:0] rs, input logic [7:0] exp, input string what);
      host_cpu_model_inst.bus_rd(rs, q);
      chk8(what, exp, q);
   endtask
   // Explicit index load, never reached by stepping past a boundary
   task automatic idx(input logic [10:0] v);
      wr(3'h5, {5'h00, v[10:8]});
      wr(3'h4, v[7:0]);
   endtask
   task automatic wait_px;
      repeat (3) @(posedge clk);
      #1;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int i = 0; i < 5; i++) begin
         host_cpu_model_inst.bus_wr_rd(rows[i].rs, rows[i].d, q);
         chk8("register row", rows[i].exp, q);
      end
      // Second reset in mid-run restores the defaults
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(3'h2, 8'hff, "mask reset");
      rd(3'h3, 8'h00, "address reset");
      rd(3'h7, 8'h00, "ctrl reset");
      // Six-bit write at the top entry, address wraps
      wr(3'h0, 8'hff);
      wr(3'h1, 8'h3f);
      wr(3'h1, 8'hd5);
      wr(3'h1, 8'hea);
      repeat (2) @(posedge clk);
      rd(3'h0, 8'h00, "write wrap");
      wr(3'h3, 8'hff);
      // Colors land two cycles after the read-mode load
      repeat (2) @(posedge clk);
      rd(3'h1, 8'h3f, "six red");
      wr(3'h2, 8'h0f);
      idx(11'h071);
      rd(3'h1, 8'h15, "six green");
      rd(3'h1, 8'h2a, "six blue");
      repeat (2) @(posedge clk);
      rd(3'h0, 8'h01, "read wrap");
      // Eight-bit mode shows the stored low bits
      wr(3'h6, 8'h04);
      wr(3'h3, 8'hff);
      repeat (2) @(posedge clk);
      rd(3'h1, 8'hfc, "full red");
      rd(3'h1, 8'h54, "full green");
      rd(3'h1, 8'ha8, "full blue");
      wr(3'h0, 8'h10);
      wr(3'h1, 8'h81);
      wr(3'h1, 8'h42);
      wr(3'h1, 8'h03);
      wr(3'h3, 8'h10);
      repeat (2) @(posedge clk);
      rd(3'h1, 8'h81, "eight red");
      rd(3'h1, 8'h42, "eight green");
      rd(3'h1, 8'h03, "eight blue");
      // Mask takes effect on the pixel path, checked three clocks after each write
      wr(3'h2, 8'hff);
      wait_px();
      chk24("pixel", 24'hfc54a8, pixel_color);
      wr(3'h2, 8'h10);
      wait_px();
      chk24("masked pixel", 24'h814203, pixel_color);
      // Status format
      idx(11'h070);
      wr(3'h6, 8'h01);
      wr(3'h3, 8'h20);
      rd(3'h3, 8'h03, "read status");
      rd(3'h0, 8'h21, "address beside status");
      wr(3'h0, 8'h40);
      rd(3'h3, 8'h00, "write status");
      // Cursor array with and without stepping
      wr(3'h7, 8'h01);
      idx(11'h100);
      wr(3'h6, 8'h11);
      wr(3'h6, 8'h22);
      rd(3'h4, 8'h02, "stepped index");
      idx(11'h100);
      rd(3'h6, 8'h11, "cursor first");
      rd(3'h6, 8'h22, "cursor second");
      wr(3'h7, 8'h00);
      idx(11'h100);
      rd(3'h6, 8'h11, "held first");
      rd(3'h6, 8'h11, "held again");
      wr(3'h4, 8'h05);
      rd(3'h5, 8'h01, "high kept");
      print_verdict();
   end
   // Watchdog
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      print_verdict();
   end
endmodule
